// ### ectl_access_ctrl.sv
module ectl_access_ctrl #(
  parameter int AL_WORDS = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic ee_scl,
  input wire logic ee_sda_i,
  output logic ee_sda_o,
  output logic ee_sda_oe,
  output logic al_valid,
  output logic [6:0] al_index,
  output logic [15:0] al_word
);
  typedef enum logic [10:0] {
    S_IDLE = 11'h001,
    S_STA = 11'h002,
    S_DEV = 11'h004,
    S_ADR = 11'h008,
    S_RSTA = 11'h010,
    S_DEVR = 11'h020,
    S_RDH = 11'h040,
    S_RDL = 11'h080,
    S_WRH = 11'h100,
    S_WRL = 11'h200,
    S_STO = 11'h400
  } ectl_st_t;

  ectl_st_t st_r;
  ectl_st_t st_nxt;
  logic issued_r;
  logic fail_r;
  logic al_pend_r;
  logic al_busy_r;
  logic [6:0] al_idx_r;
  logic start_r;
  logic dir_r;
  logic err_r;
  logic cmpl_r;
  logic [1:0] div_r;
  logic aldis_r;
  logic fast_r;
  logic [6:0] addr_r;
  logic [15:0] data_r;
  logic [7:0] hi_r;
  logic [7:0] lo_r;
  logic [2:0] ist_r;
  logic [2:0] ien_r;
  logic irq_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic sda_s1_r;
  logic sda_s2_r;
  logic sda_o_r;
  logic al_valid_r;
  logic [6:0] al_index_r;
  logic [15:0] al_word_r;

  wire tick;
  wire bio_done;
  wire bio_ack;
  wire [7:0] bio_rx;
  wire bio_go;
  wire [1:0] bio_op;
  wire [7:0] bio_tx;
  wire bio_ackout;
  wire is_tx_st;
  wire nack;
  wire al_start;
  wire sw_start;
  wire cyc_end;
  wire al_last;
  wire al_next;
  wire al_fin;
  wire sw_fin;
  wire rd_ok;
  wire [6:0] cyc_addr;
  wire cyc_wr;
  wire setup;
  wire acc;
  wire wr_acc;
  wire hit_ctl;
  wire hit_ist;
  wire hit_iclr;
  wire hit_ien;
  wire mapped;
  wire [31:0] ctl_rd;
  wire [31:0] rd_mux;
  wire ctl_wr;
  wire ctl_free;
  wire sw_go;
  wire [2:0] ev;
  wire [2:0] ist_clr;

  // APB decode; zero-wait access, pready answers in the access phase
  assign setup = psel && !penable;
  assign acc = psel && penable && pready_r;
  assign wr_acc = acc && pwrite;
  assign hit_ctl = (paddr == ectl_pkg::ADDR_CTL);
  assign hit_ist = (paddr == ectl_pkg::ADDR_IST);
  assign hit_iclr = (paddr == ectl_pkg::ADDR_ICLR);
  assign hit_ien = (paddr == ectl_pkg::ADDR_IEN);
  assign mapped = hit_ctl || hit_ist || hit_iclr || hit_ien;
  assign ctl_rd = {data_r, addr_r, al_busy_r, fast_r, aldis_r, div_r, cmpl_r, err_r, dir_r, start_r};
  assign rd_mux = hit_ctl ? ctl_rd :
                  hit_ist ? {29'h0, ist_r} :
                  hit_ien ? {29'h0, ien_r} : 32'h0;
  assign ctl_wr = wr_acc && hit_ctl;
  // Address, direction and data hold still while a software access runs
  assign ctl_free = ctl_wr && !start_r;
  assign sw_go = ctl_wr && pwdata[ectl_pkg::B_START] && !start_r;

  // Cycle sequencing
  assign cyc_addr = al_busy_r ? al_idx_r : addr_r;
  assign cyc_wr = !al_busy_r && dir_r;
  assign bio_go = (st_r != S_IDLE) && !issued_r;
  assign bio_op = (st_r == S_STA || st_r == S_RSTA) ? ectl_pkg::OP_START :
                  (st_r == S_STO) ? ectl_pkg::OP_STOP :
                  (st_r == S_RDH || st_r == S_RDL) ? ectl_pkg::OP_RX : ectl_pkg::OP_TX;
  assign bio_tx = (st_r == S_DEV) ? ectl_pkg::DEV_WR :
                  (st_r == S_DEVR) ? ectl_pkg::DEV_RD :
                  (st_r == S_ADR) ? {1'b0, cyc_addr} :
                  (st_r == S_WRH) ? data_r[15:8] :
                  (st_r == S_WRL) ? data_r[7:0] : 8'h00;
  // Acknowledge the high byte, not the last one
  assign bio_ackout = (st_r == S_RDH);
  assign is_tx_st = (st_r == S_DEV) || (st_r == S_ADR) || (st_r == S_DEVR) ||
                    (st_r == S_WRH) || (st_r == S_WRL);
  assign nack = bio_done && is_tx_st && !bio_ack;
  assign al_start = (st_r == S_IDLE) && al_pend_r && !aldis_r;
  assign sw_start = (st_r == S_IDLE) && !al_pend_r && start_r;
  assign cyc_end = (st_r == S_STO) && bio_done;
  assign al_last = (al_idx_r == 7'(AL_WORDS - 1));
  // Setting the disable bit ends a running autoload after the word in flight
  assign al_next = cyc_end && al_busy_r && !fail_r && !al_last && !aldis_r;
  assign al_fin = cyc_end && al_busy_r && (fail_r || al_last || aldis_r);
  assign sw_fin = cyc_end && !al_busy_r;
  assign rd_ok = sw_fin && !dir_r && !fail_r;
  assign ev = {al_fin, nack, sw_fin};
  assign ist_clr = (wr_acc && hit_iclr) ? pwdata[2:0] : 3'h0;

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign ee_sda_o = sda_o_r;
  assign al_valid = al_valid_r;
  assign al_index = al_index_r;
  assign al_word = al_word_r;

  ectl_clkdiv #(
    .CW(11)
  ) u_div (
    .clk_sys(clk_sys),
    .rst(rst),
    .sel(div_r),
    .fast(fast_r && al_busy_r),
    .tick(tick)
  );

  ectl_byteio u_bio (
    .clk_sys(clk_sys),
    .rst(rst),
    .tick(tick),
    .op_valid(bio_go),
    .op(bio_op),
    .tx_byte(bio_tx),
    .ack_out(bio_ackout),
    .sda_in(sda_s2_r),
    .done(bio_done),
    .ack_ok(bio_ack),
    .rx_byte(bio_rx),
    .scl(ee_scl),
    .sda_oe(ee_sda_oe)
  );

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      S_IDLE: if (al_start || sw_start) st_nxt = S_STA;
      S_STA: if (bio_done) st_nxt = S_DEV;
      S_DEV: if (bio_done) st_nxt = nack ? S_STO : S_ADR;
      S_ADR: if (bio_done) st_nxt = nack ? S_STO : (cyc_wr ? S_WRH : S_RSTA);
      S_RSTA: if (bio_done) st_nxt = S_DEVR;
      S_DEVR: if (bio_done) st_nxt = nack ? S_STO : S_RDH;
      S_RDH: if (bio_done) st_nxt = S_RDL;
      S_RDL: if (bio_done) st_nxt = S_STO;
      S_WRH: if (bio_done) st_nxt = nack ? S_STO : S_WRL;
      S_WRL: if (bio_done) st_nxt = S_STO;
      S_STO: if (bio_done) st_nxt = al_next ? S_STA : S_IDLE;
      default: st_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= S_IDLE;
      issued_r <= 1'b0;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_o_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      issued_r <= bio_done ? 1'b0 : (issued_r || bio_go);
      sda_s1_r <= ee_sda_i;
      sda_s2_r <= sda_s1_r;
      sda_o_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fail_r <= 1'b0;
      err_r <= 1'b0;
      hi_r <= 8'h00;
      lo_r <= 8'h00;
    end else begin
      fail_r <= (st_r == S_IDLE) ? 1'b0 : (fail_r || nack);
      if (nack) begin
        err_r <= 1'b1;
      end else if (al_start || sw_start) begin
        err_r <= 1'b0;
      end
      if (bio_done && st_r == S_RDH) begin
        hi_r <= bio_rx;
      end
      if (bio_done && st_r == S_RDL) begin
        lo_r <= bio_rx;
      end
    end
  end

  // Autoload runs once after reset unless disabled by then
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      al_pend_r <= 1'b1;
      al_busy_r <= 1'b0;
      al_idx_r <= 7'h00;
      cmpl_r <= 1'b0;
      al_valid_r <= 1'b0;
      al_index_r <= 7'h00;
      al_word_r <= 16'h0000;
    end else begin
      if (st_r == S_IDLE) begin
        al_pend_r <= 1'b0;
      end
      if (al_start) begin
        al_busy_r <= 1'b1;
      end else if (al_fin) begin
        al_busy_r <= 1'b0;
      end
      if (al_start) begin
        al_idx_r <= 7'h00;
      end else if (al_next) begin
        al_idx_r <= al_idx_r + 7'h01;
      end
      if (al_start) begin
        cmpl_r <= 1'b0;
      end else if (al_fin && !fail_r && al_last) begin
        cmpl_r <= 1'b1;
      end
      al_valid_r <= cyc_end && al_busy_r && !fail_r;
      if (cyc_end && al_busy_r) begin
        al_index_r <= al_idx_r;
        al_word_r <= {hi_r, lo_r};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      start_r <= 1'b0;
      dir_r <= ectl_pkg::RST_DIR;
      div_r <= ectl_pkg::RST_DIV;
      aldis_r <= ectl_pkg::RST_ALDIS;
      fast_r <= ectl_pkg::RST_FAST;
      addr_r <= ectl_pkg::RST_ADR;
      data_r <= ectl_pkg::RST_DAT;
    end else begin
      if (sw_go) begin
        start_r <= 1'b1;
      end else if (sw_fin) begin
        start_r <= 1'b0;
      end
      if (ctl_wr) begin
        div_r <= pwdata[ectl_pkg::B_DIV +: 2];
        aldis_r <= pwdata[ectl_pkg::B_ALDIS];
        fast_r <= pwdata[ectl_pkg::B_FAST];
      end
      if (ctl_free) begin
        dir_r <= pwdata[ectl_pkg::B_DIR];
        addr_r <= pwdata[ectl_pkg::B_ADR +: 7];
      end
      if (rd_ok) begin
        data_r <= {hi_r, lo_r};
      end else if (ctl_free) begin
        data_r <= pwdata[ectl_pkg::B_DAT +: 16];
      end
    end
  end

  // Events set sticky status; a clear in the same cycle loses
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ist_r <= 3'h0;
      ien_r <= 3'h0;
      irq_r <= 1'b0;
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      ist_r <= (ist_r & ~ist_clr) | ev;
      if (wr_acc && hit_ien) begin
        ien_r <= pwdata[2:0];
      end
      irq_r <= |(ist_r & ien_r);
      pready_r <= setup;
      pslverr_r <= setup && !mapped;
      if (setup) begin
        prdata_r <= rd_mux;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_start_clear: assert property ($fell(start_r) |-> $past(st_r == S_STO && bio_done && !al_busy_r))
    else $error("start bit cleared outside the end of a software cycle");
  a_start_go: assert property ((start_r && st_r == S_IDLE && !al_pend_r) |=> st_r == S_STA)
    else $error("pending software cycle did not begin");
  a_err_nack: assert property ((bio_done && is_tx_st && !bio_ack) |=> err_r)
    else $error("missing acknowledge not flagged");
  a_err_cause: assert property ($rose(err_r) |-> $past(nack))
    else $error("error flag set without a missing acknowledge");
  a_cmpl_cause: assert property ($rose(cmpl_r) |-> $past(al_busy_r && al_last && !fail_r && cyc_end))
    else $error("completion set without a clean last autoload word");
  a_al_skip: assert property ((cyc_end && al_busy_r && aldis_r) |=> !al_busy_r && st_r == S_IDLE)
    else $error("autoload went on while disabled");
  a_busy_rise: assert property ($rose(al_busy_r) |-> ##1 st_r == S_STA ##0 ctl_rd[ectl_pkg::B_BUSY])
    else $error("busy flag not tied to autoload start");
  a_addr_sent: assert property ((st_r == S_ADR && bio_go && !al_busy_r) |-> bio_tx == {1'b0, addr_r})
    else $error("wrong word address sent");
  a_wr_data: assert property ((st_r != S_IDLE && !al_busy_r && !rd_ok) |=> $stable(data_r))
    else $error("data field changed during a software cycle");
  a_rd_load: assert property ((sw_fin && !dir_r && !fail_r) |=> data_r == {$past(hi_r), $past(lo_r)})
    else $error("read word not loaded before start cleared");

  c_al_done: cover property ($rose(cmpl_r));
  c_sw_write: cover property (sw_fin && dir_r && !fail_r);
  c_sw_read: cover property (sw_fin && !dir_r && !fail_r);
  c_nack: cover property (nack);
endmodule : ectl_access_ctrl

// ### ectl_pkg.sv
package ectl_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTL = 8'h70;
  localparam logic [7:0] ADDR_IST = 8'h80;
  localparam logic [7:0] ADDR_ICLR = 8'h84;
  localparam logic [7:0] ADDR_IEN = 8'h88;
  // Control/status field positions
  localparam int B_START = 0;
  localparam int B_DIR = 1;
  localparam int B_ERR = 2;
  localparam int B_CMPL = 3;
  localparam int B_DIV = 4;
  localparam int B_ALDIS = 6;
  localparam int B_FAST = 7;
  localparam int B_BUSY = 8;
  localparam int B_ADR = 9;
  localparam int B_DAT = 16;
  // Reset values
  localparam logic [1:0] RST_DIV = 2'h0;
  localparam logic RST_ALDIS = 1'b0;
  localparam logic RST_FAST = 1'b1;
  localparam logic RST_DIR = 1'b0;
  localparam logic [6:0] RST_ADR = 7'h00;
  localparam logic [15:0] RST_DAT = 16'h0000;
  // Serial clock divisors of the core clock, per divider code
  localparam int DIV_C0 = 4096;
  localparam int DIV_C1 = 2048;
  localparam int DIV_C2 = 1024;
  localparam int DIV_C3 = 128;
  localparam int PHASES = 4;
  localparam int FAST_SHIFT = 5;
  // Interrupt status bits
  localparam int IRQ_SW = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_AL = 2;
  localparam int IRQ_W = 3;
  // Serial device select bytes
  localparam logic [7:0] DEV_WR = 8'hA0;
  localparam logic [7:0] DEV_RD = 8'hA1;
  // Byte engine operations
  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_STOP = 2'h1,
    OP_TX = 2'h2,
    OP_RX = 2'h3
  } ectl_op_t;
endpackage : ectl_pkg

// ### ectl_clkdiv.sv
module ectl_clkdiv #(
  parameter int CW = 11
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [1:0] sel,
  input wire logic fast,
  output logic tick
);
  localparam logic [CW-1:0] Q0 = CW'(ectl_pkg::DIV_C0 / ectl_pkg::PHASES);
  localparam logic [CW-1:0] Q1 = CW'(ectl_pkg::DIV_C1 / ectl_pkg::PHASES);
  localparam logic [CW-1:0] Q2 = CW'(ectl_pkg::DIV_C2 / ectl_pkg::PHASES);
  localparam logic [CW-1:0] Q3 = CW'(ectl_pkg::DIV_C3 / ectl_pkg::PHASES);

  logic [CW-1:0] cnt_r;
  logic tick_r;
  wire [CW-1:0] qtr;
  wire [CW-1:0] eff;
  wire [CW-1:0] load;

  // One tick per quarter of a serial clock period
  assign qtr = (sel == 2'h0) ? Q0 : (sel == 2'h1) ? Q1 : (sel == 2'h2) ? Q2 : Q3;
  assign eff = fast ? (qtr >> ectl_pkg::FAST_SHIFT) : qtr;
  assign load = eff - CW'(1);
  assign tick = tick_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (cnt_r == '0) begin
      cnt_r <= load;
      tick_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r - CW'(1);
      tick_r <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // The reload value is taken one cycle before the tick, so the rate inputs are looked at there
  a_slow_gap: assert property ((tick_r && !$past(fast) && $past(sel) == 2'h0) |=> !tick_r [*8])
    else $error("quarter period too short at slowest divider");
  a_fast_rate: assert property ((tick_r && $past(fast) && $past(sel) == 2'h0) |-> ##32 tick_r)
    else $error("fast autoload quarter period not 32 times shorter at slowest divider");
endmodule : ectl_clkdiv

// ### ectl_byteio.sv
module ectl_byteio (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic tick,
  input wire logic op_valid,
  input wire logic [1:0] op,
  input wire logic [7:0] tx_byte,
  input wire logic ack_out,
  input wire logic sda_in,
  output logic done,
  output logic ack_ok,
  output logic [7:0] rx_byte,
  output logic scl,
  output logic sda_oe
);
  logic run_r;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic [1:0] op_r;
  logic [7:0] sh_r;
  logic scl_r;
  logic oe_r;
  logic done_r;
  logic ack_r;
  wire is_byte;
  wire last_bit;
  wire fin;
  wire drive_bit;
  wire oe_p0;
  wire scl_nxt;
  wire oe_nxt;

  assign is_byte = (op_r == ectl_pkg::OP_TX) || (op_r == ectl_pkg::OP_RX);
  assign last_bit = (bit_r == 4'h8);
  assign fin = (ph_r == 2'h3) && (!is_byte || last_bit);
  // Ninth bit: released to read the acknowledge, or driven as ours
  assign drive_bit = (op_r == ectl_pkg::OP_TX) ? (!last_bit && !sh_r[7]) : (last_bit && ack_out);
  assign oe_p0 = (op_r == ectl_pkg::OP_START) ? 1'b0 : (op_r == ectl_pkg::OP_STOP) ? 1'b1 : drive_bit;
  assign scl_nxt = (ph_r == 2'h1) || (ph_r == 2'h2) || (ph_r == 2'h3 && op_r == ectl_pkg::OP_STOP);
  assign oe_nxt = (ph_r == 2'h0) ? oe_p0 :
                  (ph_r == 2'h2 && op_r == ectl_pkg::OP_START) ? 1'b1 :
                  (ph_r == 2'h2 && op_r == ectl_pkg::OP_STOP) ? 1'b0 : oe_r;
  assign done = done_r;
  assign ack_ok = ack_r;
  assign rx_byte = sh_r;
  assign scl = scl_r;
  assign sda_oe = oe_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      run_r <= 1'b0;
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      op_r <= 2'h0;
      sh_r <= 8'h00;
      scl_r <= 1'b1;
      oe_r <= 1'b0;
      done_r <= 1'b0;
      ack_r <= 1'b1;
    end else begin
      done_r <= 1'b0;
      if (!run_r && op_valid) begin
        run_r <= 1'b1;
        op_r <= op;
        sh_r <= tx_byte;
        ph_r <= 2'h0;
        bit_r <= 4'h0;
      end else if (run_r && tick) begin
        scl_r <= scl_nxt;
        oe_r <= oe_nxt;
        ph_r <= ph_r + 2'h1;
        if (ph_r == 2'h2 && is_byte && !last_bit) begin
          sh_r <= {sh_r[6:0], sda_in};
        end
        if (ph_r == 2'h2 && last_bit) begin
          ack_r <= !sda_in;
        end
        if (ph_r == 2'h3) begin
          bit_r <= bit_r + 4'h1;
        end
        if (fin) begin
          run_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end
endmodule : ectl_byteio

// ### ectl_eeprom_mdl.sv
module ectl_eeprom_mdl (
  input wire logic scl,
  input wire logic sda,
  input wire logic nack_en,
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [128];
  logic [7:0] sh;
  logic [7:0] txb;
  logic [7:0] whi;
  logic [6:0] wa;
  logic tx;
  logic go_tx;
  logic mack;
  int cnt;
  int nb;
  initial begin
    sda_pull = 1'b0;
    tx = 1'b0;
    go_tx = 1'b0;
    cnt = 0;
    nb = 0;
    for (int i = 0; i < 128; i++) begin
      mem[i] = 16'hA500 | 16'(i);
    end
  end
  // Start and stop are data edges while the clock is high
  always @(negedge sda) if (scl === 1'b1) begin
    cnt = 0;
    nb = 0;
    tx = 1'b0;
    go_tx = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    cnt = 0;
    nb = 9;
    tx = 1'b0;
  end
  always @(posedge scl) begin
    if (cnt < 8) sh = {sh[6:0], sda};
    else mack = ~sda;
    cnt++;
  end
  // Data changes only while the clock is low
  always @(negedge scl) begin
    if (cnt == 8) begin
      sda_pull = ~tx & ~nack_en;
      if (!tx && nb == 0) go_tx = sh[0];
      if (!tx && nb == 1) wa = sh[6:0];
      if (!tx && nb == 2) whi = sh;
      if (!tx && nb == 3) mem[wa] = {whi, sh};
      nb++;
    end else if (cnt == 9) begin
      cnt = 0;
      if (go_tx) txb = mem[wa][15:8];
      else if (tx) txb = mem[wa][7:0];
      tx = go_tx | (tx & mack);
      go_tx = 1'b0;
    end
    if (cnt < 8) sda_pull = tx & ~txb[7 - cnt];
  end
endmodule : ectl_eeprom_mdl

// ### serial_eeprom_access_ctrl_tb.sv
module serial_eeprom_access_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AL = 2;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, irq, ee_scl, ee_sda_o, ee_sda_oe, al_valid, mdl_pull;
  logic nack_en = 1'b0;
  logic [6:0] al_index;
  logic [15:0] al_word;
  wire logic sda_line = ~(ee_sda_oe | mdl_pull);
  logic [65:0] exp_q [$];
  logic [22:0] al_q [$];
  int per_q [$];
  int error_cnt = 0;
  int check_count = 0;
  int per = 0;
  int b, n;
  logic scl_d = 1'b1;
  logic [65:0] xe;
  logic [31:0] rs = 32'h0000005E;
  logic [31:0] rd_v;
  logic [15:0] wd;
  logic [6:0] wadr, a2;

  ectl_access_ctrl #(.AL_WORDS(AL)) u_ectl_access_ctrl (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .ee_scl(ee_scl), .ee_sda_i(sda_line), .ee_sda_o(ee_sda_o),
    .ee_sda_oe(ee_sda_oe), .al_valid(al_valid), .al_index(al_index), .al_word(al_word));
  ectl_eeprom_mdl u_ectl_eeprom_mdl (.scl(ee_scl), .sda(sda_line), .nack_en(nack_en), .sda_pull(mdl_pull));

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  task automatic give_up;
    error_cnt++;
    $display("MISMATCH at %0t: wait ran out", $time);
    end_of_test();
  endtask : give_up

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] m,
                     input logic [32:0] e);
    int k;
    exp_q.push_back({m, e});
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd_v = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) give_up();
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000, {1'b1, m}, {1'b0, e});
  endtask : rdc

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h100000000, 33'h000000000);
  endtask : wr

  task automatic wait_irq(input int lim);
    int k;
    k = 0;
    while (irq !== 1'b1 && k < lim) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= lim) give_up();
  endtask : wait_irq

  // Scoreboard side: serial clock periods, bus answers and loaded words
  always @(posedge clk_sys) begin
    scl_d <= ee_scl;
    if (ee_scl === 1'b1 && scl_d === 1'b0) begin
      per_q.push_back(per);
      per <= 1;
    end else begin
      per <= per + 1;
    end
    if (psel && penable && pready === 1'b1) begin
      xe = exp_q.pop_front();
      chk({pslverr, prdata} & xe[65:33], xe[32:0]);
    end
    if (al_valid === 1'b1) begin
      chk({10'h000, al_index, al_word}, {10'h000, al_q.pop_front()});
    end
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < AL; i++) begin
      al_q.push_back({7'(i), 16'hA500 | 16'(i)});
    end
    b = per_q.size();
    repeat (3) @(posedge clk_sys);
    rdc(ectl_pkg::ADDR_CTL, 32'hFFFFFFFF, 32'h00000180);
    for (int w = 0; w < 2; w++) begin
      apb(1'(w), 8'h74, 32'hFFFFFFFF, 33'h100000000, 33'h100000000);
    end
    wr(ectl_pkg::ADDR_IEN, 32'h00000007);
    wait_irq(40000);
    chk(33'(per_q[b + 4]), 33'(ectl_pkg::DIV_C0 >> ectl_pkg::FAST_SHIFT));
    rdc(ectl_pkg::ADDR_CTL, 32'h0000010C, 32'h00000008);
    rdc(ectl_pkg::ADDR_IST, 32'h00000007, 32'h00000004);
    wr(ectl_pkg::ADDR_ICLR, 32'h00000007);
    repeat (3) @(posedge clk_sys);
    chk({32'h00000000, irq}, 33'h000000000);
    rs = xs(rs);
    wd = rs[15:0];
    wadr = rs[22:16];
    a2 = wadr ^ 7'h55;
    b = per_q.size();
    wr(ectl_pkg::ADDR_CTL, {wd, wadr, 3'h0, 2'h3, 2'h0, 2'h3});
    wait_irq(20000);
    chk(33'(per_q[b + 4]), 33'(ectl_pkg::DIV_C3));
    chk({17'h00000, u_ectl_eeprom_mdl.mem[wadr]}, {17'h00000, wd});
    rdc(ectl_pkg::ADDR_CTL, 32'hFFFFFFFF, {wd, wadr, 3'h0, 2'h3, 2'h2, 2'h2});
    wr(ectl_pkg::ADDR_ICLR, 32'h00000007);
    // Read back the written word, then an untouched one
    for (int i = 0; i < 2; i++) begin
      wr(ectl_pkg::ADDR_CTL, {16'h0000, (i == 1) ? a2 : wadr, 3'h0, 2'h3, 4'h1});
      wait_irq(20000);
      rdc(ectl_pkg::ADDR_CTL, 32'hFFFF0003, {(i == 1) ? (16'hA500 | {9'h000, a2}) : wd, 16'h0000});
      wr(ectl_pkg::ADDR_ICLR, 32'h00000007);
    end
    nack_en <= 1'b1;
    wr(ectl_pkg::ADDR_IEN, 32'h00000000);
    for (int c = 2; c > 0; c--) begin
      b = per_q.size();
      wr(ectl_pkg::ADDR_CTL, {16'h1234, 7'h01, 3'h0, 2'(c), 4'h3});
      n = 0;
      rd_v = 32'h00000001;
      while (rd_v[0] !== 1'b0 && n < 10000) begin
        rdc(ectl_pkg::ADDR_CTL, 32'h00000000, 32'h00000000);
        n++;
      end
      if (n >= 10000) give_up();
      chk(33'(per_q[b + 4]), 33'((c == 2) ? ectl_pkg::DIV_C2 : ectl_pkg::DIV_C1));
      chk({32'h00000000, irq}, 33'h000000000);
      rdc(ectl_pkg::ADDR_CTL, 32'h00000005, 32'h00000004);
      rdc(ectl_pkg::ADDR_IST, 32'h00000007, 32'h00000003);
    end
    nack_en <= 1'b0;
    wr(ectl_pkg::ADDR_IEN, 32'h00000002);
    repeat (3) @(posedge clk_sys);
    chk({32'h00000000, irq}, 33'h000000001);
    wr(ectl_pkg::ADDR_ICLR, 32'h00000007);
    repeat (3) @(posedge clk_sys);
    chk({32'h00000000, irq}, 33'h000000000);
    // Second reset: autoload starts at once; disabling it stops after the word in flight
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    al_q.push_back({7'h00, 16'hA500});
    wr(ectl_pkg::ADDR_IEN, 32'h00000004);
    wr(ectl_pkg::ADDR_CTL, 32'h000000C0);
    wait_irq(20000);
    rdc(ectl_pkg::ADDR_CTL, 32'h000001CC, 32'h000000C0);
    chk({32'h00000000, ee_sda_o}, 33'h000000000);
    chk(33'(al_q.size()), 33'h000000000);
    end_of_test();
  end
endmodule : serial_eeprom_access_ctrl_tb
